// [verilog/hpac_regs.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hpac_params.svh"
// Function
// (RQ1) Gain code steps 1.5 dB; code 0x15 is -57.0 dB.
// (RQ2) Codes 0x00 to 0x14 are reserved; software avoids them, no gain meaning.
// (RQ3) Gain rises monotonically; 0x3B is 0 dB, 0x3F is +6.0 dB.
// (RQ4) Right gain uses same encoding, resets to 0x3B.
// (RQ5) Right control bit 7 enables amplifier, resets off.
// (RQ6) Right control bit 6 mutes, resets muted.
// (RQ7) Bit 5 set glides gain stepwise; clear applies new gain at once.
// (RQ8) Glide overrides zero-cross update when both set.
// (RQ9) Bit 4 with glide off defers gain change until audio crosses zero.
// (RQ10) Bit 3 drives output when set, high impedance when clear; resets zero.
// (RQ11) Bit 2 forces minimum gain regardless of programmed code.
// (RQ12) Detect register bit 6 enables load sensing on both channels.
// (RQ13) Read-only load status: bit 2 right, bit 1 left, one means load.
// (RQ14) Read-only bit 0 reports stereo load, resets zero.
// (RQ15) Output config bit 4: zero charge pump, one direct single supply.
// (RQ16) Output config bit 0: zero single-ended, one differential.
// (RQ17) Supply bit write needs key 0xC3 written to key register first.
// (RQ18) Left control register mirrors right control bits, mute resets one.
// (RQ19) Reserved gain codes stored and read back unchanged, no clamping.
// (RQ20) Detect register bit 7 is read-write stereo sensing enable, resets zero.
module hpac_regs (
	input  wire logic            ref_clk_in,
	input  wire logic            nrst_in,
	input  wire logic [7:0]      addr_in,
	input  wire hpac_pkg::hpac_byte_t wdata_in,
	input  wire logic            wr_in,
	input  wire logic            rd_in,
	output logic [7:0]           rdata_out,
	input  wire logic            left_load_cmp_in,
	input  wire logic            right_load_cmp_in,
	input  wire logic            stereo_cmp_in,
	input  wire logic            left_audio_sign_in,
	input  wire logic            right_audio_sign_in,
	output logic                 left_amplifier_on_out,
	output logic                 left_silence_out,
	output logic                 left_output_drive_out,
	output hpac_pkg::hpac_gain_t left_gain_code_out,
	output logic                 right_amplifier_on_out,
	output logic                 right_silence_out,
	output logic                 right_output_drive_out,
	output hpac_pkg::hpac_gain_t right_gain_code_out,
	output logic                 load_sense_on_out,
	output logic                 stereo_sense_on_out,
	output logic                 direct_supply_select_out,
	output logic                 balanced_output_select_out
);
	import hpac_pkg::*;

	// Channel 0 is left, channel 1 is right
	logic [7:2]  chan_ctrl [2];
	hpac_gain_t  chan_gain [2];
	logic        stereo_sense_on;
	logic        load_sense_on;
	logic        direct_supply_select;
	logic        balanced_output_select;
	logic        supply_bit_key;
	logic [1:0]  load_seen;
	logic        stereo_load_seen;
	logic [2:0]  cmp_meta;
	logic [2:0]  cmp_sync;
	logic [1:0]  sign_meta;
	logic [1:0]  sign_sync;
	logic [1:0]  sign_prev;
	logic [7:0]  next_rdata;
	hpac_gain_t  applied [2];
	logic [1:0]  sign_raw;

	hpac_gain_if gif [2] ();

	// Address decode for write strobes
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr, input logic strobe);
		hit = strobe && (a == ref_addr);
	endfunction

	// Gain delivered to the path: floor override or programmed code
	function automatic hpac_gain_t eff_gain(input logic [7:2] ctl, input hpac_gain_t code);
		if (ctl[`HPAC_CTL_FLOOR_BIT]) begin
			eff_gain = `HPAC_GAIN_MIN; // [RQ11]
		end else begin
			eff_gain = code; // [RQ19]
		end
	endfunction

	// Readback of a channel control register; low two bits are reserved
	function automatic logic [7:0] ctl_byte(input logic [7:2] ctl);
		ctl_byte = {ctl, 2'b00};
	endfunction

	// Readback of a gain register; top two bits are reserved
	function automatic logic [7:0] gain_byte(input hpac_gain_t code);
		gain_byte = {2'b00, code};
	endfunction

	assign sign_raw = {right_audio_sign_in, left_audio_sign_in};

	// Two-flop synchronisers for comparator pins
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cmp_meta <= 3'h0;
			cmp_sync <= 3'h0;
		end else begin
			cmp_meta <= {stereo_cmp_in, right_load_cmp_in, left_load_cmp_in};
			cmp_sync <= cmp_meta;
		end
	end

	// Two-flop synchronisers for audio sign
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sign_meta <= 2'h0;
			sign_sync <= 2'h0;
		end else begin
			sign_meta <= sign_raw;
			sign_sync <= sign_meta;
		end
	end

	// Previous synced sign; resets to the idle pin level so no false crossing follows reset
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sign_prev <= 2'h0;
		end else begin
			sign_prev <= sign_sync;
		end
	end

	// Per-channel control and gain registers
	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_chan
			localparam logic [7:0] CTRL_ADDR = (ch == 0) ? `HPAC_ADDR_LEFT_CTRL : `HPAC_ADDR_RIGHT_CTRL;
			localparam logic [7:0] GAIN_ADDR = (ch == 0) ? `HPAC_ADDR_LEFT_GAIN : `HPAC_ADDR_RIGHT_GAIN;
			localparam logic [5:0] GAIN_RST  = (ch == 0) ? `HPAC_LEFT_GAIN_RESET : `HPAC_RIGHT_GAIN_RESET;

			// Control bits: on, silence, glide, zero cross, drive, floor
			always_ff @(posedge ref_clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					chan_ctrl[ch] <= `HPAC_CTL_RESET; // [RQ5] [RQ6] [RQ10] [RQ18]
				end else if (hit(addr_in, CTRL_ADDR, wr_in)) begin
					chan_ctrl[ch] <= wdata_in[7:2]; // [RQ18]
				end
			end

			// Gain code, stored as written
			always_ff @(posedge ref_clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					chan_gain[ch] <= GAIN_RST; // [RQ4]
				end else if (hit(addr_in, GAIN_ADDR, wr_in)) begin
					chan_gain[ch] <= wdata_in[5:0]; // [RQ19] [RQ2]
				end
			end

			// Feed the gain path
			assign gif[ch].target    = eff_gain(chan_ctrl[ch], chan_gain[ch]); // [RQ11]
			assign gif[ch].glide     = chan_ctrl[ch][`HPAC_CTL_GLIDE_BIT]; // [RQ7]
			assign gif[ch].zc        = chan_ctrl[ch][`HPAC_CTL_ZC_BIT]; // [RQ9]
			assign gif[ch].zero_seen = sign_sync[ch] ^ sign_prev[ch]; // [RQ9]
			assign applied[ch]       = gif[ch].applied;

			hpac_gain_path u_path (
				.ref_clk_in    (ref_clk_in),
				.nrst_in       (nrst_in),
				.reset_code_in (GAIN_RST),
				.gif           (gif[ch])
			);
		end
	endgenerate

	// Stereo sensing enable, a plain read-write bit
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stereo_sense_on <= 1'b0;
		end else if (hit(addr_in, `HPAC_ADDR_DETECT_CTRL, wr_in)) begin
			stereo_sense_on <= wdata_in[`HPAC_DET_STEREO_EN_BIT]; // [RQ20]
		end
	end

	// Load sensing enable, shared by both channels
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			load_sense_on <= 1'b0;
		end else if (hit(addr_in, `HPAC_ADDR_DETECT_CTRL, wr_in)) begin
			load_sense_on <= wdata_in[`HPAC_DET_LOAD_EN_BIT]; // [RQ12]
		end
	end

	// Load status; zero from one cycle after sensing turns off, so a stale result can read back for that one cycle
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			load_seen <= 2'h0;
		end else begin
			load_seen <= load_sense_on ? cmp_sync[1:0] : 2'h0; // [RQ13] [RQ12]
		end
	end

	// Stereo status, gated by its own enable
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stereo_load_seen <= 1'b0;
		end else begin
			stereo_load_seen <= stereo_sense_on & cmp_sync[2]; // [RQ14]
		end
	end

	// Supply key: armed by the code, spent by the next config write
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			supply_bit_key <= 1'b0;
		end else if (hit(addr_in, `HPAC_ADDR_SUPPLY_KEY, wr_in)) begin
			supply_bit_key <= (wdata_in == `HPAC_SUPPLY_KEY_CODE); // [RQ17]
		end else if (hit(addr_in, `HPAC_ADDR_OUTPUT_CFG, wr_in)) begin
			supply_bit_key <= 1'b0;
		end
	end

	// Output mode bit, writable at any time
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			balanced_output_select <= 1'b0; // [RQ16]
		end else if (hit(addr_in, `HPAC_ADDR_OUTPUT_CFG, wr_in)) begin
			balanced_output_select <= wdata_in[`HPAC_CFG_BALANCED_BIT]; // [RQ16]
		end
	end

	// Supply bit; an unkeyed write leaves the supply scheme alone
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			direct_supply_select <= 1'b0; // [RQ15]
		end else if (hit(addr_in, `HPAC_ADDR_OUTPUT_CFG, wr_in) && supply_bit_key) begin
			direct_supply_select <= wdata_in[`HPAC_CFG_SUPPLY_BIT]; // [RQ15] [RQ17]
		end
	end

	// Read mux
	always_comb begin
		next_rdata = 8'h00;
		case (addr_in)
			`HPAC_ADDR_LEFT_CTRL:   next_rdata = ctl_byte(chan_ctrl[0]);
			`HPAC_ADDR_LEFT_GAIN:   next_rdata = gain_byte(chan_gain[0]);
			`HPAC_ADDR_RIGHT_CTRL:  next_rdata = ctl_byte(chan_ctrl[1]);
			`HPAC_ADDR_RIGHT_GAIN:  next_rdata = gain_byte(chan_gain[1]);
			`HPAC_ADDR_DETECT_CTRL: next_rdata = {stereo_sense_on, load_sense_on, 3'b000,
				load_seen[1], load_seen[0], stereo_load_seen}; // [RQ13] [RQ14]
			`HPAC_ADDR_OUTPUT_CFG:  next_rdata = {3'b000, direct_supply_select, 3'b000, balanced_output_select};
			default:                next_rdata = 8'h00;
		endcase
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= 8'h00;
		end else begin
			rdata_out <= rd_in ? next_rdata : 8'h00;
		end
	end

	// Left amplifier enable
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			left_amplifier_on_out <= 1'b0;
		end else begin
			left_amplifier_on_out <= chan_ctrl[0][`HPAC_CTL_ON_BIT]; // [RQ18]
		end
	end

	// Left mute, starts muted
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			left_silence_out <= 1'b1;
		end else begin
			left_silence_out <= chan_ctrl[0][`HPAC_CTL_SILENCE_BIT]; // [RQ18]
		end
	end

	// Left output drive request
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			left_output_drive_out <= 1'b0;
		end else begin
			left_output_drive_out <= chan_ctrl[0][`HPAC_CTL_DRIVE_BIT]; // [RQ18]
		end
	end

	// Left applied gain
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			left_gain_code_out <= `HPAC_LEFT_GAIN_RESET;
		end else begin
			left_gain_code_out <= applied[0]; // [RQ1] [RQ3]
		end
	end

	// Right amplifier enable
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			right_amplifier_on_out <= 1'b0;
		end else begin
			right_amplifier_on_out <= chan_ctrl[1][`HPAC_CTL_ON_BIT]; // [RQ5]
		end
	end

	// Right mute, starts muted
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			right_silence_out <= 1'b1;
		end else begin
			right_silence_out <= chan_ctrl[1][`HPAC_CTL_SILENCE_BIT]; // [RQ6]
		end
	end

	// Right output drive request
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			right_output_drive_out <= 1'b0;
		end else begin
			right_output_drive_out <= chan_ctrl[1][`HPAC_CTL_DRIVE_BIT]; // [RQ10]
		end
	end

	// Right applied gain
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			right_gain_code_out <= `HPAC_RIGHT_GAIN_RESET;
		end else begin
			right_gain_code_out <= applied[1]; // [RQ4]
		end
	end

	// Detect enable outputs
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			load_sense_on_out   <= 1'b0;
			stereo_sense_on_out <= 1'b0;
		end else begin
			load_sense_on_out   <= load_sense_on; // [RQ12]
			stereo_sense_on_out <= stereo_sense_on; // [RQ20]
		end
	end

	// Supply and output mode outputs
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			direct_supply_select_out   <= 1'b0;
			balanced_output_select_out <= 1'b0;
		end else begin
			direct_supply_select_out   <= direct_supply_select; // [RQ15]
			balanced_output_select_out <= balanced_output_select; // [RQ16]
		end
	end
endmodule
`default_nettype wire

// [inc/hpac_params.svh]
`ifndef HPAC_PARAMS_SVH
`define HPAC_PARAMS_SVH

// Register offsets
`define HPAC_ADDR_LEFT_CTRL     8'hD0
`define HPAC_ADDR_LEFT_GAIN     8'hD1
`define HPAC_ADDR_RIGHT_CTRL    8'hD2
`define HPAC_ADDR_RIGHT_GAIN    8'hD3
`define HPAC_ADDR_DETECT_CTRL   8'hD4
`define HPAC_ADDR_OUTPUT_CFG    8'hD5
`define HPAC_ADDR_SUPPLY_KEY    8'hD7

// Channel control field positions
`define HPAC_CTL_ON_BIT         7
`define HPAC_CTL_SILENCE_BIT    6
`define HPAC_CTL_GLIDE_BIT      5
`define HPAC_CTL_ZC_BIT         4
`define HPAC_CTL_DRIVE_BIT      3
`define HPAC_CTL_FLOOR_BIT      2

// Detect control field positions
`define HPAC_DET_STEREO_EN_BIT  7
`define HPAC_DET_LOAD_EN_BIT    6
`define HPAC_DET_RIGHT_LOAD_BIT 2
`define HPAC_DET_LEFT_LOAD_BIT  1
`define HPAC_DET_STEREO_BIT     0

// Output config field positions
`define HPAC_CFG_SUPPLY_BIT     4
`define HPAC_CFG_BALANCED_BIT   0

// Reset values and codes
`define HPAC_CTL_RESET          6'h10
`define HPAC_LEFT_GAIN_RESET    6'h3B
`define HPAC_RIGHT_GAIN_RESET   6'h3B
`define HPAC_GAIN_UNITY         6'h3B
`define HPAC_GAIN_MIN           6'h15
`define HPAC_GAIN_MAX           6'h3F
`define HPAC_SUPPLY_KEY_CODE    8'hC3

// Timing
`define HPAC_CLK_PERIOD_NS      100
`define HPAC_RAMP_STEP_NS       10000
`define HPAC_RAMP_STEP_CYC      ((`HPAC_RAMP_STEP_NS + `HPAC_CLK_PERIOD_NS - 1) / `HPAC_CLK_PERIOD_NS)

`endif

// [inc/hpac_pkg.sv]
package hpac_pkg;
	typedef logic [5:0] hpac_gain_t;
	typedef logic [7:0] hpac_byte_t;

	// Gain update behaviour of one channel
	typedef enum logic [1:0] {
		HPAC_UPD_IDLE  = 2'b00,
		HPAC_UPD_GLIDE = 2'b01,
		HPAC_UPD_ZC    = 2'b10
	} hpac_upd_e;
endpackage

// [inc/hpac_gain_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface hpac_gain_if;
	import hpac_pkg::*;
	hpac_gain_t target;
	logic       glide;
	logic       zero_seen;
	logic       zc;
	hpac_gain_t applied;

	modport ctrl (output target, output glide, output zc, output zero_seen, input applied);
	modport path (input target, input glide, input zc, input zero_seen, output applied);
endinterface
`default_nettype wire

// [verilog/hpac_gain_path.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hpac_params.svh"
module hpac_gain_path (
	input  wire logic       ref_clk_in,
	input  wire logic       nrst_in,
	input  wire logic [5:0] reset_code_in,
	hpac_gain_if.path       gif
);
	import hpac_pkg::*;

	localparam logic [15:0] STEP_CYC = 16'(`HPAC_RAMP_STEP_CYC);

	hpac_upd_e  state;
	logic [15:0] step_cnt;
	logic        loaded;

	// Update mode follows target; glide outranks zero cross
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= HPAC_UPD_IDLE;
		end else begin
			case (state)
				HPAC_UPD_IDLE: begin
					if (loaded && gif.target != gif.applied) begin
						if (gif.glide) begin
							state <= HPAC_UPD_GLIDE; // [RQ7] [RQ8]
						end else if (gif.zc) begin
							state <= HPAC_UPD_ZC; // [RQ9]
						end
					end
				end
				HPAC_UPD_GLIDE: begin
					if (gif.target == gif.applied || !gif.glide) begin
						state <= HPAC_UPD_IDLE;
					end
				end
				HPAC_UPD_ZC: begin
					if (gif.glide || gif.zero_seen || !gif.zc || gif.target == gif.applied) begin
						state <= HPAC_UPD_IDLE;
					end
				end
				default: state <= HPAC_UPD_IDLE;
			endcase
		end
	end

	// Step interval timer for gliding
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			step_cnt <= 16'h0000;
		end else if (state != HPAC_UPD_GLIDE || step_cnt == STEP_CYC - 16'h0001) begin
			step_cnt <= 16'h0000;
		end else begin
			step_cnt <= step_cnt + 16'h0001;
		end
	end

	// Load reset code once after release
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			loaded <= 1'b0;
		end else begin
			loaded <= 1'b1;
		end
	end

	// Applied gain code, one 1.5 dB step per glide interval
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			gif.applied <= `HPAC_GAIN_UNITY; // Equals both reset codes, so no dip after release
		end else if (!loaded) begin
			gif.applied <= reset_code_in;
		end else begin
			case (state)
				HPAC_UPD_IDLE: begin
					if (!gif.glide && !gif.zc) begin
						gif.applied <= gif.target; // [RQ7]
					end
				end
				HPAC_UPD_GLIDE: begin
					if (step_cnt == STEP_CYC - 16'h0001) begin
						if (gif.target > gif.applied) begin
							gif.applied <= gif.applied + 6'h01; // [RQ7] [RQ3]
						end else if (gif.target < gif.applied) begin
							gif.applied <= gif.applied - 6'h01; // [RQ7]
						end
					end
				end
				HPAC_UPD_ZC: begin
					if (!gif.glide && (gif.zero_seen || !gif.zc)) begin
						gif.applied <= gif.target; // [RQ9]
					end
				end
				default: gif.applied <= gif.applied;
			endcase
		end
	end
endmodule
`default_nettype wire

// [verif/hpac_regs_checker.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hpac_params.svh"
module hpac_regs_checker (
	input  wire logic                 ref_clk_in,
	input  wire logic                 nrst_in,
	input  wire logic [7:0]           addr_in,
	input  wire hpac_pkg::hpac_byte_t wdata_in,
	input  wire logic                 wr_in,
	input  wire logic                 right_amplifier_on_out,
	input  wire logic                 right_silence_out,
	input  wire logic                 right_output_drive_out,
	input  wire hpac_pkg::hpac_gain_t right_gain_code_out,
	input  wire logic                 left_silence_out,
	input  wire logic                 direct_supply_select_out,
	input  wire logic                 balanced_output_select_out
);
	import hpac_pkg::*;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);

	// Decoded writes
	wire logic w_lctl  = wr_in && addr_in == `HPAC_ADDR_LEFT_CTRL;
	wire logic w_rctl  = wr_in && addr_in == `HPAC_ADDR_RIGHT_CTRL;
	wire logic w_rgain = wr_in && addr_in == `HPAC_ADDR_RIGHT_GAIN;
	wire logic w_cfg   = wr_in && addr_in == `HPAC_ADDR_OUTPUT_CFG;
	wire logic w_key   = wr_in && addr_in == `HPAC_ADDR_SUPPLY_KEY;
	logic       armed;
	logic [7:0] rctl;
	logic [7:0] rgain;
	wire logic  keyed_wr = w_cfg && armed;

	// Shadow of key state and right channel settings
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			armed <= 1'b0;
			rctl  <= 8'h40;
			rgain <= 8'h3b;
		end else begin
			if (w_key)
				armed <= (wdata_in == `HPAC_SUPPLY_KEY_CODE);
			else if (w_cfg)
				armed <= 1'b0;
			if (w_rctl)
				rctl <= wdata_in;
			if (w_rgain)
				rgain <= wdata_in;
		end
	end

	// Gain write with glide and zero-cross off, bus then quiet
	sequence s_gain_quiet;
		w_rgain && rctl[5:4] == 2'b00 ##1 !wr_in [*2];
	endsequence

	a_right_on: assert property (w_rctl |-> ##2 right_amplifier_on_out == $past(wdata_in[7], 2))
		else $error("right enable not following register");
	a_right_mute: assert property (w_rctl |-> ##2 right_silence_out == $past(wdata_in[6], 2))
		else $error("right mute not following register");
	a_right_drive: assert property (w_rctl |-> ##2 right_output_drive_out == $past(wdata_in[3], 2))
		else $error("right drive not following register");
	a_left_mute: assert property (w_lctl |-> ##2 left_silence_out == $past(wdata_in[6], 2))
		else $error("left mute not following register");
	a_balanced_follows: assert property (w_cfg |-> ##2 balanced_output_select_out == $past(wdata_in[0], 2))
		else $error("output mode not following register");
	a_supply_keyed: assert property (keyed_wr |-> ##2 direct_supply_select_out == $past(wdata_in[4], 2))
		else $error("keyed supply write not applied");
	a_supply_locked: assert property ($changed(direct_supply_select_out) |-> $past(keyed_wr, 2))
		else $error("supply mode changed without key");
	a_gain_direct: assert property (s_gain_quiet |-> ##[1:2]
		right_gain_code_out == (rctl[2] ? `HPAC_GAIN_MIN : rgain[5:0]))
		else $error("right gain not applied directly");
endmodule

bind hpac_regs hpac_regs_checker i_hpac_regs_checker (.ref_clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in,
	.right_amplifier_on_out, .right_silence_out, .right_output_drive_out, .right_gain_code_out,
	.left_silence_out, .direct_supply_select_out, .balanced_output_select_out);
`default_nettype wire

// [verif/hpac_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hpac_params.svh"
module hpac_regs_tb;
	import hpac_pkg::*;
	logic        ref_clk_in = 1'b0;
	logic        nrst_in    = 1'b0;
	logic [7:0]  addr_in    = 8'h00;
	hpac_byte_t  wdata_in   = 8'h00;
	logic        wr_in      = 1'b0;
	logic        rd_in      = 1'b0;
	logic [4:0]  pins       = 5'h00;
	logic [7:0]  rdata_out;
	logic        l_on, l_mute, l_drv, r_on, r_mute, r_drv, load_on, st_on, sup, bal;
	hpac_gain_t  l_gain, r_gain;
	logic [15:0] lfsr = 16'h8ec8;
	logic [7:0]  expq[$];
	logic [7:0]  e;
	logic        rd_q = 1'b0;
	int          n_fail = 0;
	int          checks = 0;
	logic [7:0]  adr[8] = '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd7, 8'h6e};
	logic [7:0]  rst[8] = '{8'h40, 8'h3b, 8'h40, 8'h3b, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  msk[8] = '{8'hfc, 8'h3f, 8'hfc, 8'h3f, 8'hc0, 8'h01, 8'h00, 8'h00};

	hpac_regs i_hpac_regs (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .left_load_cmp_in(pins[0]),
		.right_load_cmp_in(pins[1]), .stereo_cmp_in(pins[2]), .left_audio_sign_in(pins[3]),
		.right_audio_sign_in(pins[4]), .left_amplifier_on_out(l_on), .left_silence_out(l_mute),
		.left_output_drive_out(l_drv), .left_gain_code_out(l_gain), .right_amplifier_on_out(r_on),
		.right_silence_out(r_mute), .right_output_drive_out(r_drv), .right_gain_code_out(r_gain),
		.load_sense_on_out(load_on), .stereo_sense_on_out(st_on), .direct_supply_select_out(sup),
		.balanced_output_select_out(bal));

	// 10 MHz clock
	always #50 ref_clk_in = ~ref_clk_in;

	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp_v);
		checks++;
		if (seen !== exp_v) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp_v, seen);
		end
	endtask

	// Bus cycles, one strobe cycle each
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		expq.push_back(d);
		@(posedge ref_clk_in);
		rd_in <= 1'b0;
	endtask

	task automatic gw(input logic [7:0] ctl, input logic [7:0] g, input int n);
		wr(8'hd2, ctl);
		wr(8'hd3, g);
		repeat (n) @(posedge ref_clk_in);
	endtask

	task automatic wrap_up;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Read data against the oldest note
	always @(posedge ref_clk_in) begin
		if (rd_q)
			check("rdata", rdata_out, expq.pop_front());
		rd_q <= rd_in;
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		n_fail++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge ref_clk_in);
		nrst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		check("outs", 8'({l_on, l_mute, l_drv, r_on, r_mute, r_drv, load_on, st_on}), 8'h48);
		check("cfg", 8'({sup, bal}), 8'h00);
		check("rgain", 8'(r_gain), 8'h3b);
		foreach (adr[k]) rd(adr[k], rst[k]);
		// Random write and masked readback, unmapped included
		repeat (3) foreach (adr[k]) begin
			lfsr = nxt(lfsr);
			wr(adr[k], (k == 6) ? 8'h00 : lfsr[7:0]);
			rd(adr[k], lfsr[7:0] & msk[k]);
		end
		// Random control bits reach the outputs
		repeat (4) begin
			lfsr = nxt(lfsr);
			wr(8'hd0, lfsr[7:0] & 8'hc8);
			wr(8'hd2, lfsr[15:8] & 8'hc8);
			wr(8'hd4, lfsr[7:0] & 8'hc0);
			wr(8'hd5, {7'h00, lfsr[9]});
			repeat (3) @(posedge ref_clk_in);
			e = {lfsr[7:6], lfsr[3], lfsr[15:14], lfsr[11], lfsr[6], lfsr[7]};
			check("ctl", 8'({l_on, l_mute, l_drv, r_on, r_mute, r_drv, load_on, st_on}), e);
			check("bal", 8'(bal), 8'(lfsr[9]));
		end
		// Gain codes, floor, zero cross, glide
		wr(8'hd0, 8'h80);
		wr(8'hd1, 8'h2a);
		gw(8'h80, 8'h15, 6);
		check("lgain", 8'(l_gain), 8'h2a);
		check("rgain", 8'(r_gain), 8'h15);
		gw(8'h80, 8'h3f, 6);
		check("rgain", 8'(r_gain), 8'h3f);
		gw(8'h84, 8'h3f, 6);
		check("floor", 8'(r_gain), 8'h15);
		gw(8'h80, 8'h3f, 6);
		check("floor", 8'(r_gain), 8'h3f);
		gw(8'h90, 8'h20, 20);
		check("zc", 8'(r_gain), 8'h3f);
		pins[4] <= ~pins[4];
		repeat (8) @(posedge ref_clk_in);
		check("zc", 8'(r_gain), 8'h20);
		wr(8'hd0, 8'h90);
		wr(8'hd1, 8'h30);
		repeat (8) @(posedge ref_clk_in);
		check("lzc", 8'(l_gain), 8'h2a);
		pins[3] <= ~pins[3];
		repeat (8) @(posedge ref_clk_in);
		check("lzc", 8'(l_gain), 8'h30);
		gw(8'hb0, 8'h22, 40);
		check("glide", 8'(r_gain inside {6'h20, 6'h21}), 8'h01);
		repeat (300) @(posedge ref_clk_in);
		check("glide", 8'(r_gain), 8'h22);
		// Supply key, one shot and disarm
		wr(8'hd5, 8'h11);
		rd(8'hd5, 8'h01);
		wr(8'hd7, 8'hc3);
		wr(8'hd5, 8'h11);
		rd(8'hd5, 8'h11);
		wr(8'hd5, 8'h00);
		rd(8'hd5, 8'h10);
		check("supply", 8'({sup, bal}), 8'h02);
		wr(8'hd7, 8'hc3);
		wr(8'hd7, 8'h3c);
		wr(8'hd5, 8'h01);
		rd(8'hd5, 8'h11);
		// Load and stereo status
		wr(8'hd4, 8'hc0);
		pins[2:0] <= 3'b111;
		repeat (6) @(posedge ref_clk_in);
		rd(8'hd4, 8'hc7);
		pins[0] <= 1'b0;
		repeat (6) @(posedge ref_clk_in);
		rd(8'hd4, 8'hc5);
		wr(8'hd4, 8'h00);
		repeat (4) @(posedge ref_clk_in);
		rd(8'hd4, 8'h00);
		repeat (3) @(posedge ref_clk_in);
		wrap_up();
	end
endmodule
`default_nettype wire
